/* File: rtl/sbsr_top.v */
// Serial byte data shift register with AXI4-Lite register access
//
// Added by the designer: the address map and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`include "sbsr_map.vh"
module sbsr_top (
  input wire core_clk,
  input wire reset_n,
  input wire [`SBSR_ADDR_W-1:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  output wire [1:0] s_axi_bresp,
  output wire s_axi_bvalid,
  input wire s_axi_bready,
  input wire [`SBSR_ADDR_W-1:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  output wire [31:0] s_axi_rdata,
  output wire [1:0] s_axi_rresp,
  output wire s_axi_rvalid,
  input wire s_axi_rready,
  input wire sclIn,
  input wire sdaIn,
  output wire sdaOut,
  output wire sdaOe,
  output wire irq
);
  localparam ST_IDLE = 2'd0;
  localparam ST_SHIFT = 2'd1;
  localparam ST_PAUSE = 2'd2;

  wire sclLevel;
  wire sclRise;
  wire sclFall;
  wire sdaLevel;
  wire [7:0] shData;
  wire shMsb;

  reg [1:0] state_r;
  reg [1:0] state_nxt;
  reg [3:0] bitCnt_r;
  reg enable_r;
  reg xmit_r;
  reg event_r;
  reg lost_r;
  reg driveBit_r;
  reg [`SBSR_STAT_W-1:0] stat_r;
  reg [`SBSR_STAT_W-1:0] mask_r;
  reg [`SBSR_ADDR_W-1:0] awAddr_r;
  reg awHave_r;
  reg [31:0] wData_r;
  reg [3:0] wStrb_r;
  reg wHave_r;
  reg bValid_r;
  reg [1:0] bResp_r;
  reg rValid_r;
  reg [31:0] rData_r;
  reg [1:0] rResp_r;

  function mapped;
    input [`SBSR_ADDR_W-1:0] a;
    begin
      mapped = (a == `SBSR_OFF_DATA) || (a == `SBSR_OFF_CTRL) ||
        (a == `SBSR_OFF_STAT) || (a == `SBSR_OFF_MASK);
    end
  endfunction

  // Registers sit on whole words; the two low address bits are ignored
  function [`SBSR_ADDR_W-1:0] wordAddr;
    input [`SBSR_ADDR_W-1:0] a;
    begin
      wordAddr = {a[`SBSR_ADDR_W-1:2], 2'b00};
    end
  endfunction

  // Both pins cross in through two flops that reset to the idle high level,
  // so no false edge follows reset
  sbsr_sync u_sclSync (
    .core_clk(core_clk),
    .reset_n(reset_n),
    .async(sclIn),
    .level(sclLevel),
    .rise(sclRise),
    .fall(sclFall)
  );

  sbsr_sync u_sdaSync (
    .core_clk(core_clk),
    .reset_n(reset_n),
    .async(sdaIn),
    .level(sdaLevel),
    .rise(),
    .fall()
  );

  // Write channel completion and decode
  wire doWrite = awHave_r & wHave_r & ~bValid_r;
  wire wrData = doWrite & (awAddr_r == `SBSR_OFF_DATA) & wStrb_r[0];
  wire wrCtrl = doWrite & (awAddr_r == `SBSR_OFF_CTRL) & wStrb_r[0];
  wire wrMask = doWrite & (awAddr_r == `SBSR_OFF_MASK) & wStrb_r[0];
  // Data writes only count while paused between bytes or while disabled
  wire dataOpen = event_r | ~enable_r;
  wire loadShift = wrData & dataOpen;
  // One read at a time: a new address is taken only once the last answer is gone
  wire doRead = s_axi_arvalid & ~rValid_r;
  wire rdStat = doRead & (wordAddr(s_axi_araddr) == `SBSR_OFF_STAT);

  // Sample the line on the rising clock edge, keeping the bit in step with the output
  wire sampleNow = (state_r == ST_SHIFT) & sclRise;
  // Arbitration lost: we released sda high but the bus reads low
  wire arbLost = sampleNow & xmit_r & driveBit_r & ~sdaLevel;
  wire byteDone = sampleNow & (bitCnt_r == `SBSR_BITS_PER_BYTE - 4'h1);

  // Link state: idle until enabled, shifting, then paused between bytes
  always @* begin
    state_nxt = state_r;
    case (state_r)
      ST_IDLE: begin
        if (enable_r) begin
          state_nxt = ST_SHIFT;
        end
      end
      ST_SHIFT: begin
        if (!enable_r) begin
          state_nxt = ST_IDLE;
        end else if (byteDone) begin
          state_nxt = ST_PAUSE;
        end
      end
      ST_PAUSE: begin
        if (!enable_r) begin
          state_nxt = ST_IDLE;
        end else if (wrCtrl && !wData_r[`SBSR_CTRL_EVENT]) begin
          state_nxt = ST_SHIFT;
        end
      end
      default: begin
        state_nxt = ST_IDLE;
      end
    endcase
  end

  // Shift and sample share one edge, so the byte always holds what the bus showed
  sbsr_shifter #(
    .WIDTH(8)
  ) u_shifter (
    .core_clk(core_clk),
    .reset_n(reset_n),
    .load(loadShift),
    .loadData(wData_r[7:0]),
    .shift(sampleNow),
    .sdaIn(sdaLevel),
    .data(shData),
    .msb(shMsb)
  );

  // Link sequencing: state and bit counter
  always @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      state_r <= ST_IDLE;
      bitCnt_r <= 4'h0;
    end else begin
      state_r <= state_nxt;
      if (state_nxt != ST_SHIFT) begin
        bitCnt_r <= 4'h0;
      end else if (sampleNow) begin
        bitCnt_r <= bitCnt_r + 4'h1;
      end
    end
  end

  // Output bit changes only while the clock line is low, except that disabling releases it at once; letting go of a low
  // data line with the clock high would look like a stop condition on the bus
  always @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      driveBit_r <= 1'b1;
    end else if (state_r == ST_SHIFT && !sclLevel && !sclFall) begin
      driveBit_r <= xmit_r ? shMsb : 1'b1;
    end else if (state_r != ST_SHIFT && (!sclLevel || !enable_r)) begin
      driveBit_r <= 1'b1;
    end
  end

  // Control register, taken from the held write data
  always @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      enable_r <= 1'b0;
      xmit_r <= 1'b0;
    end else begin
      if (wrCtrl) begin
        enable_r <= wData_r[`SBSR_CTRL_ENABLE];
      end
      // Falling to receiver keeps the shifted data intact
      if (arbLost) begin
        xmit_r <= 1'b0;
      end else if (wrCtrl) begin
        xmit_r <= wData_r[`SBSR_CTRL_XMIT];
      end
    end
  end

  // Hardware-set flags: an event in the cycle of a clearing write wins
  always @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      event_r <= 1'b0;
      lost_r <= 1'b0;
    end else begin
      if (byteDone) begin
        event_r <= 1'b1;
      end else if (wrCtrl && !wData_r[`SBSR_CTRL_EVENT]) begin
        event_r <= 1'b0;
      end
      if (arbLost) begin
        lost_r <= 1'b1;
      end else if (wrCtrl && !wData_r[`SBSR_CTRL_LOST]) begin
        lost_r <= 1'b0;
      end
    end
  end

  // Sticky status and its mask; set wins over the clear-on-read
  always @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      stat_r <= {`SBSR_STAT_W{1'b0}};
      mask_r <= {`SBSR_STAT_W{1'b0}};
    end else begin
      stat_r <= (rdStat ? {`SBSR_STAT_W{1'b0}} : stat_r) | {arbLost, byteDone};
      if (wrMask) begin
        mask_r <= wData_r[`SBSR_STAT_W-1:0];
      end
    end
  end

  // AXI4-Lite write side: address and data taken in either order
  always @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      awAddr_r <= {`SBSR_ADDR_W{1'b0}};
      awHave_r <= 1'b0;
      wData_r <= 32'h00000000;
      wStrb_r <= 4'h0;
      wHave_r <= 1'b0;
      bValid_r <= 1'b0;
      bResp_r <= `SBSR_RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        awAddr_r <= wordAddr(s_axi_awaddr);
        awHave_r <= 1'b1;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wData_r <= s_axi_wdata;
        wStrb_r <= s_axi_wstrb;
        wHave_r <= 1'b1;
      end
      if (doWrite) begin
        awHave_r <= 1'b0;
        wHave_r <= 1'b0;
        bValid_r <= 1'b1;
        bResp_r <= mapped(awAddr_r) ? `SBSR_RESP_OKAY : `SBSR_RESP_SLVERR;
      end else if (bValid_r && s_axi_bready) begin
        bValid_r <= 1'b0;
      end
    end
  end

  assign s_axi_awready = ~awHave_r & ~bValid_r;
  assign s_axi_wready = ~wHave_r & ~bValid_r;
  assign s_axi_bvalid = bValid_r;
  assign s_axi_bresp = bResp_r;

  // The write path reads wdata from its holding register; ctrl decode uses that copy
  // AXI4-Lite read side
  always @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      rValid_r <= 1'b0;
      rData_r <= 32'h00000000;
      rResp_r <= `SBSR_RESP_OKAY;
    end else if (doRead) begin
      rValid_r <= 1'b1;
      rResp_r <= mapped(wordAddr(s_axi_araddr)) ?
        `SBSR_RESP_OKAY : `SBSR_RESP_SLVERR;
      case (wordAddr(s_axi_araddr))
        `SBSR_OFF_DATA: rData_r <= {24'h000000, shData};
        `SBSR_OFF_CTRL: rData_r <= {28'h0000000, lost_r, event_r, xmit_r, enable_r};
        `SBSR_OFF_STAT: rData_r <= {30'h00000000, stat_r};
        `SBSR_OFF_MASK: rData_r <= {30'h00000000, mask_r};
        default: rData_r <= 32'h00000000;
      endcase
    end else if (rValid_r && s_axi_rready) begin
      rValid_r <= 1'b0;
    end
  end

  assign s_axi_arready = ~rValid_r;
  assign s_axi_rvalid = rValid_r;
  assign s_axi_rdata = rData_r;
  assign s_axi_rresp = rResp_r;

  // Open drain: drive only a low
  assign sdaOut = 1'b0;
  assign sdaOe = ~driveBit_r;
  assign irq = |(stat_r & mask_r);
endmodule

/* File: common/sbsr_map.vh */
// Register map, field positions, bit count and response codes of the serial byte shift register
`ifndef SBSR_MAP_VH
`define SBSR_MAP_VH
`define SBSR_ADDR_W 4
`define SBSR_OFF_DATA 4'h0
`define SBSR_OFF_CTRL 4'h4
`define SBSR_OFF_STAT 4'h8
`define SBSR_OFF_MASK 4'hC
`define SBSR_CTRL_ENABLE 0
`define SBSR_CTRL_XMIT 1
`define SBSR_CTRL_EVENT 2
`define SBSR_CTRL_LOST 3
`define SBSR_STAT_BYTE 0
`define SBSR_STAT_LOST 1
`define SBSR_STAT_W 2
`define SBSR_BITS_PER_BYTE 4'h8
`define SBSR_RESP_OKAY 2'h0
`define SBSR_RESP_SLVERR 2'h2
`endif

/* File: rtl/sbsr_sync.v */
// Two-flop synchroniser with edge detection on the settled level
`timescale 1ns/1ps
module sbsr_sync (
  input wire core_clk,
  input wire reset_n,
  input wire async,
  output wire level,
  output wire rise,
  output wire fall
);
  reg meta_r;
  reg sync_r;
  reg last_r;
  always @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      meta_r <= 1'b1;
      sync_r <= 1'b1;
      last_r <= 1'b1;
    end else begin
      meta_r <= async;
      sync_r <= meta_r;
      last_r <= sync_r;
    end
  end
  assign level = sync_r;
  assign rise = sync_r & ~last_r;
  assign fall = ~sync_r & last_r;
endmodule

/* File: rtl/sbsr_shifter.v */
// Byte shift register: drives the msb out and shifts the line level in
`timescale 1ns/1ps
module sbsr_shifter #(
  parameter WIDTH = 8
) (
  input wire core_clk,
  input wire reset_n,
  input wire load,
  input wire [WIDTH-1:0] loadData,
  input wire shift,
  input wire sdaIn,
  output wire [WIDTH-1:0] data,
  output wire msb
);
  reg [WIDTH-1:0] shift_r;
  always @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      shift_r <= {WIDTH{1'b0}};
    end else if (load) begin
      shift_r <= loadData;
    end else if (shift) begin
      shift_r <= {shift_r[WIDTH-2:0], sdaIn};
    end
  end
  assign data = shift_r;
  assign msb = shift_r[WIDTH-1];
endmodule

/* File: testbench/sbsr_bus_model.sv */
// Bus partner: makes the clock line and pulls the data line low
`timescale 1ns/1ps
module sbsr_bus_model (
  input logic core_clk,
  input logic sdaOe,
  output logic sclIn,
  output logic sdaIn
);
  logic pullLow;
  // Pull-up: a released line reads high, never the last driven value
  assign sdaIn = !(sdaOe || pullLow);
  initial begin
    sclIn = 1'h1;
    pullLow = 1'h0;
  end
  // One bit per 8 core cycles; data changes only while the clock line is low, except the release after the last bit
  task automatic frame(input logic [7:0] pull, output logic [7:0] seen);
    for (int i = 7; i >= 0; i--) begin
      sclIn <= 1'h0;
      repeat (2) @(posedge core_clk);
      pullLow <= !pull[i];
      repeat (2) @(posedge core_clk);
      sclIn <= 1'h1;
      repeat (4) @(posedge core_clk);
      seen = {seen[6:0], sdaIn};
    end
    pullLow <= 1'h0;
  endtask
endmodule

/* File: testbench/sbsr_top_chk.sv */
// Port-level assertions for the serial byte shift register
`timescale 1ns/1ps
module sbsr_top_chk (
  input logic core_clk,
  input logic reset_n,
  input logic s_axi_awvalid,
  input logic s_axi_awready,
  input logic s_axi_wvalid,
  input logic s_axi_wready,
  input logic [1:0] s_axi_bresp,
  input logic s_axi_bvalid,
  input logic s_axi_bready,
  input logic s_axi_arvalid,
  input logic s_axi_arready,
  input logic [31:0] s_axi_rdata,
  input logic [1:0] s_axi_rresp,
  input logic s_axi_rvalid,
  input logic s_axi_rready,
  input logic sclIn,
  input logic sdaOut,
  input logic sdaOe
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!reset_n);
  sequence arTaken;
    s_axi_arvalid && s_axi_arready;
  endsequence
  sequence wrTaken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  // Pin level reaches the logic two to four cycles late
  sequence sclWasLow;
    !$past(sclIn, 2) || !$past(sclIn, 3) || !$past(sclIn, 4);
  endsequence
  sda_low_change_a: assert property ($changed(sdaOe) |-> sclWasLow)
    else $error("data line drive changed while clock line high");
  open_drain_a: assert property (sdaOut == 1'h0)
    else $error("data output not tied low");
  read_answer_a: assert property (arTaken |=> s_axi_rvalid)
    else $error("read answer late");
  write_answer_a: assert property (wrTaken |-> ##[1:2] s_axi_bvalid)
    else $error("write answer late");
  rd_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp))
    else $error("read answer dropped");
  wr_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write answer dropped");
  ar_block_a: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while answer pending");
  aw_block_a: assert property (s_axi_bvalid |-> !s_axi_awready)
    else $error("write taken while answer pending");
endmodule

/* File: testbench/smbus_byte_shift_register_bench.sv */
// Register-level tests of the serial byte shift register
`timescale 1ns/1ps
`define CHK(g, e) begin nTests++; if ((g) !== (e)) begin errTotal++; \
  $display("Error at %0t: got %h expected %h", $time, g, e); end end
module smbus_byte_shift_register_bench;
  logic core_clk, reset_n, s_axi_awvalid, s_axi_wvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_rready, s_axi_awready, s_axi_wready, s_axi_bvalid;
  logic s_axi_arready, s_axi_rvalid, sclIn, sdaIn, sdaOut, sdaOe, irq;
  logic [3:0] s_axi_awaddr, s_axi_araddr, s_axi_wstrb;
  logic [31:0] s_axi_wdata, s_axi_rdata, d;
  logic [1:0] s_axi_bresp, s_axi_rresp, r;
  logic [7:0] seen;
  int errTotal = 0;
  int nTests = 0;
  sbsr_top dut (.core_clk, .reset_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .sclIn, .sdaIn,
    .sdaOut, .sdaOe, .irq);
  sbsr_bus_model bus (.core_clk, .sdaOe, .sclIn, .sdaIn);
  initial begin
    core_clk = 1'h0;
    forever #20 core_clk = !core_clk;
  end
  task automatic wr(input logic [3:0] a, input logic [31:0] v);
    @(posedge core_clk);
    {s_axi_awaddr, s_axi_wdata, s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= {a, v, 3'h7};
    while (!s_axi_bvalid) begin
      @(posedge core_clk);
      if (s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wready) s_axi_wvalid <= 1'h0;
    end
    `CHK(s_axi_bresp, 2'h0)
    s_axi_bready <= 1'h0;
  endtask
  task automatic rd(input logic [3:0] a, output logic [31:0] v, output logic [1:0] e);
    @(posedge core_clk);
    {s_axi_araddr, s_axi_arvalid, s_axi_rready} <= {a, 2'h3};
    while (!s_axi_rvalid) begin
      @(posedge core_clk);
      if (s_axi_arready) s_axi_arvalid <= 1'h0;
    end
    {v, e} = {s_axi_rdata, s_axi_rresp};
    s_axi_rready <= 1'h0;
  endtask
  // Byte end: let the pin latency pass, then the event flag must allow access
  task automatic byteEnd(input logic [31:0] eData, input logic [31:0] eStat);
    repeat (4) @(posedge core_clk);
    rd(4'h4, d, r);
    `CHK(d[2], 1'h1)
    rd(4'h0, d, r);
    `CHK(d, eData)
    rd(4'h8, d, r);
    `CHK(d, eStat)
    @(posedge core_clk);
    `CHK(irq, 1'h0)
  endtask
  task automatic stopTest;
    $display("Comparisons %0d, mismatches %0d", nTests, errTotal);
    if (errTotal == 0 && nTests > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  initial begin
    #100000;
    errTotal++;
    stopTest();
  end
  initial begin
    {reset_n, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 6'h0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = {40'h0, 4'hF};
    repeat (10) @(posedge core_clk);
    reset_n <= 1'h1;
    wr(4'hC, 32'h3);
    // Last bit low: the line must stay held until the clock line drops
    wr(4'h0, 32'hA4);
    wr(4'h4, 32'h3);
    bus.frame(8'hFF, seen);
    `CHK(seen, 8'hA4)
    `CHK(irq, 1'h1)
    byteEnd(32'hA4, 32'h1);
    $display("Test transmit done");
    wr(4'hC, 32'h0);
    wr(4'h4, 32'h1);
    bus.frame(8'h3C, seen);
    `CHK(irq, 1'h0)
    byteEnd(32'h3C, 32'h1);
    $display("Test receive and mask done");
    wr(4'hC, 32'h3);
    wr(4'h0, 32'hF0);
    wr(4'h4, 32'h3);
    bus.frame(8'hB0, seen);
    `CHK(seen, 8'hB0)
    `CHK(irq, 1'h1)
    rd(4'h4, d, r);
    `CHK(d[3:1], 3'h6)
    byteEnd(32'hB0, 32'h3);
    $display("Test lost arbitration done");
    // Low address bits are ignored, so this reaches the data register
    rd(4'h2, d, r);
    `CHK(r, 2'h0)
    `CHK(d, 32'hB0)
    $display("Test word aliasing done");
    stopTest();
  end
endmodule
bind sbsr_top sbsr_top_chk chk (.core_clk, .reset_n, .s_axi_awvalid, .s_axi_awready,
  .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
  .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
  .s_axi_rready, .sclIn, .sdaOut, .sdaOe);
